/* rtl/dmp_pkg.sv */
// What this block does
// - Mode 0000 powers both pin buffers down
// - Mode 0001 makes clock pin a shared input
// - Mode 0010 makes clock pin a readable input
// - Mode 0011 drives control bit 0 out
// - Mode 0100 drives the divided clock output
// - Modes 0101/0110 drive interrupt line one/two
// - Modes 1000/1001 drive secondary bit/word clock
// - Mode 1010 drives the modulator clock
// - Bit 0 ignored outside general output mode
// - Clock register bit 1 reads input buffer
// - Data pin decodes modes like clock pin
// - Data pin output mode drives its bit 0
// - Data register bit 1 reads input buffer
`default_nettype none
package dmp_pkg;
  localparam logic [7:0] DMP_OFS_RSVD = 8'h32;
  localparam logic [7:0] DMP_OFS_CLK  = 8'h33;
  localparam logic [7:0] DMP_OFS_DAT  = 8'h34;
  localparam int DMP_MODE_LSB = 2;
  localparam int DMP_MODE_MSB = 5;
  localparam int DMP_IN_BIT   = 1;
  localparam int DMP_OUT_BIT  = 0;
  localparam logic [3:0] DMP_MODE_RST = 4'h0;
  localparam logic       DMP_OUT_RST  = 1'b0;
  typedef enum logic [3:0] {
    DMP_OFF    = 4'b0000,
    DMP_INPUT  = 4'b0001,
    DMP_GPI    = 4'b0010,
    DMP_GPO    = 4'b0011,
    DMP_DIVIDED_CLOCK_OUTPUT = 4'b0100,
    DMP_INTERRUPT_LINE_ONE   = 4'b0101,
    DMP_INTERRUPT_LINE_TWO   = 4'b0110,
    DMP_SBCLK  = 4'b1000,
    DMP_SWCLK  = 4'b1001,
    DMP_MODCLK = 4'b1010
  } dmp_mode_t;
endpackage
`default_nettype wire

/* rtl/dmp_pin.sv */
`timescale 1ns/1ns
`default_nettype none
// One multifunction pin: decodes its mode into buffer enables and output level.
module dmp_pin (
  input  wire logic       clk,          // System clock.
  input  wire logic       rst_n,        // Asynchronous reset, active low.
  input  wire logic [3:0] mode,         // Mode field.
  input  wire logic       gpo_val,      // Software output level.
  input  wire logic       divided_clock_output_src,   // Divided clock output.
  input  wire logic       int_one,      // Interrupt line one.
  input  wire logic       int_two,      // Interrupt line two.
  input  wire logic       sbclk_src,    // Secondary bit clock out.
  input  wire logic       swclk_src,    // Secondary word clock out.
  input  wire logic       modclk_src,   // Modulator clock.
  input  wire logic       pad_i,        // Pad level.
  output logic            pad_o,        // Pad drive level.
  output logic            pad_oe,       // Pad drive enable.
  output logic            in_buf,       // Input buffer state.
  output logic            in_route,     // Level to audio logic in input mode.
  output logic            gpi_route     // Level in general input mode.
);
  logic next_o;
  logic next_oe;
  logic in_en;

  always_comb
  begin
    next_oe = 1'b1;
    next_o  = 1'b0;
    unique case (mode)
      dmp_pkg::DMP_GPO:    next_o = gpo_val;
      dmp_pkg::DMP_DIVIDED_CLOCK_OUTPUT: next_o = divided_clock_output_src;
      dmp_pkg::DMP_INTERRUPT_LINE_ONE:   next_o = int_one;
      dmp_pkg::DMP_INTERRUPT_LINE_TWO:   next_o = int_two;
      dmp_pkg::DMP_SBCLK:  next_o = sbclk_src;
      dmp_pkg::DMP_SWCLK:  next_o = swclk_src;
      dmp_pkg::DMP_MODCLK: next_o = modclk_src;
      default:             next_oe = 1'b0;
    endcase
  end

  // Input buffer is on in every mode but power down.
  assign in_en = (mode != dmp_pkg::DMP_OFF);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pad_o  <= 1'b0;
      pad_oe <= 1'b0;
    end
    else
    begin
      pad_o  <= next_o;
      pad_oe <= next_oe;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_buf    <= 1'b0;
      in_route  <= 1'b0;
      gpi_route <= 1'b0;
    end
    else
    begin
      in_buf    <= in_en & pad_i;
      in_route  <= (mode == dmp_pkg::DMP_INPUT) & pad_i;
      gpi_route <= (mode == dmp_pkg::DMP_GPI) & pad_i;
    end
  end

  a_off_no_drive: assert property (@(posedge clk) disable iff (!rst_n)
    mode == dmp_pkg::DMP_OFF |=> !pad_oe) else $error("pad driven while off");
  a_gpo_level: assert property (@(posedge clk) disable iff (!rst_n)
    mode == dmp_pkg::DMP_GPO |=> pad_oe && pad_o == $past(gpo_val))
    else $error("gpo level wrong");
  a_divided_clock_output_follow: assert property (@(posedge clk) disable iff (!rst_n)
    mode == dmp_pkg::DMP_DIVIDED_CLOCK_OUTPUT |=> pad_o == $past(divided_clock_output_src))
    else $error("divided_clock_output not routed");
  a_int_follow: assert property (@(posedge clk) disable iff (!rst_n)
    mode == dmp_pkg::DMP_INTERRUPT_LINE_TWO |=> pad_o == $past(int_two))
    else $error("int two not routed");
  a_sclk_follow: assert property (@(posedge clk) disable iff (!rst_n)
    mode == dmp_pkg::DMP_SWCLK |=> pad_o == $past(swclk_src))
    else $error("word clock not routed");
  a_mod_follow: assert property (@(posedge clk) disable iff (!rst_n)
    mode == dmp_pkg::DMP_MODCLK |=> pad_oe && pad_o == $past(modclk_src))
    else $error("modulator clock not routed");
  a_input_hiz: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == dmp_pkg::DMP_INPUT || mode == dmp_pkg::DMP_GPI) |=> !pad_oe)
    else $error("input mode drives pad");
  a_gpi_read: assert property (@(posedge clk) disable iff (!rst_n)
    mode == dmp_pkg::DMP_GPI |=> in_buf == $past(pad_i))
    else $error("input buffer stale");
  a_bit0_ignored: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == dmp_pkg::DMP_INTERRUPT_LINE_ONE && $stable(int_one) && $changed(gpo_val)) |=>
    pad_o == $past(int_one)) else $error("bit 0 leaks out");
  c_gpo: cover property (@(posedge clk) mode == dmp_pkg::DMP_GPO ##1 pad_o);
  c_gpi: cover property (@(posedge clk) mode == dmp_pkg::DMP_GPI ##1 in_buf);
  c_mod: cover property (@(posedge clk) mode == dmp_pkg::DMP_MODCLK ##1 pad_oe);
endmodule
`default_nettype wire

/* rtl/dmp_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
// Register file for the two pin control registers and both pins.
module dmp_ctrl (
  input  wire logic       clk,          // System clock.
  input  wire logic       rst_n,        // Asynchronous reset, active low.
  input  wire logic [7:0] reg_addr,     // Register offset.
  input  wire logic       reg_wr,       // Write strobe.
  input  wire logic [7:0] reg_wdata,    // Write data.
  output logic      [7:0] reg_rdata,    // Read data, registered.
  input  wire logic       divided_clock_output_src,   // Divided clock output.
  input  wire logic       int_one,      // Interrupt line one.
  input  wire logic       int_two,      // Interrupt line two.
  input  wire logic       sbclk_src,    // Secondary bit clock out.
  input  wire logic       swclk_src,    // Secondary word clock out.
  input  wire logic       modclk_src,   // Modulator clock.
  input  wire logic       mic_clock_pin_i,   // Clock pad level.
  output logic            mic_clock_pin_o,   // Clock pad drive level.
  output logic            mic_clock_pin_oe,  // Clock pad drive enable.
  output logic            mic_clock_pin_in,  // Clock pad level in input mode.
  output logic            mic_clock_pin_gpi, // Clock pad level in general input mode.
  input  wire logic       mic_data_pin_i,    // Data pad level.
  output logic            mic_data_pin_o,    // Data pad drive level.
  output logic            mic_data_pin_oe,   // Data pad drive enable.
  output logic            mic_data_pin_in,   // Data pad level in input mode.
  output logic            mic_data_pin_gpi   // Data pad level in general input mode.
);
  logic [3:0] mode_q [2];
  logic [1:0] gpo_q;
  logic [1:0] in_buf;
  logic [1:0] pad_i;
  logic [1:0] pad_o;
  logic [1:0] pad_oe;
  logic [1:0] in_r;
  logic [1:0] gpi_r;
  logic [7:0] next_rdata;

  assign pad_i = {mic_data_pin_i, mic_clock_pin_i};

  function automatic logic [7:0] dmp_pack(input logic [3:0] m, input logic ib, input logic g);
    dmp_pack = {2'b00, m, ib, g};
  endfunction

  // Writes to the reserved offset and to read-only bits are dropped.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_q[0] <= dmp_pkg::DMP_MODE_RST;
      mode_q[1] <= dmp_pkg::DMP_MODE_RST;
      gpo_q     <= {2{dmp_pkg::DMP_OUT_RST}};
    end
    else if (reg_wr && reg_addr == dmp_pkg::DMP_OFS_CLK)
    begin
      mode_q[0] <= reg_wdata[dmp_pkg::DMP_MODE_MSB:dmp_pkg::DMP_MODE_LSB];
      gpo_q[0]  <= reg_wdata[dmp_pkg::DMP_OUT_BIT];
    end
    else if (reg_wr && reg_addr == dmp_pkg::DMP_OFS_DAT)
    begin
      mode_q[1] <= reg_wdata[dmp_pkg::DMP_MODE_MSB:dmp_pkg::DMP_MODE_LSB];
      gpo_q[1]  <= reg_wdata[dmp_pkg::DMP_OUT_BIT];
    end
  end

  always_comb
  begin
    next_rdata = 8'h00;
    if (reg_addr == dmp_pkg::DMP_OFS_CLK)
      next_rdata = dmp_pack(mode_q[0], in_buf[0], gpo_q[0]);
    else if (reg_addr == dmp_pkg::DMP_OFS_DAT)
      next_rdata = dmp_pack(mode_q[1], in_buf[1], gpo_q[1]);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= next_rdata;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_pin
      dmp_pin u_pin (
        .clk        (clk),
        .rst_n      (rst_n),
        .mode       (mode_q[gi]),
        .gpo_val    (gpo_q[gi]),
        .divided_clock_output_src (divided_clock_output_src),
        .int_one    (int_one),
        .int_two    (int_two),
        .sbclk_src  (sbclk_src),
        .swclk_src  (swclk_src),
        .modclk_src (modclk_src),
        .pad_i      (pad_i[gi]),
        .pad_o      (pad_o[gi]),
        .pad_oe     (pad_oe[gi]),
        .in_buf     (in_buf[gi]),
        .in_route   (in_r[gi]),
        .gpi_route  (gpi_r[gi])
      );
    end
  endgenerate

  assign mic_clock_pin_o   = pad_o[0];
  assign mic_clock_pin_oe  = pad_oe[0];
  assign mic_clock_pin_in  = in_r[0];
  assign mic_clock_pin_gpi = gpi_r[0];
  assign mic_data_pin_o    = pad_o[1];
  assign mic_data_pin_oe   = pad_oe[1];
  assign mic_data_pin_in   = in_r[1];
  assign mic_data_pin_gpi  = gpi_r[1];

  a_write_applies: assert property (@(posedge clk) disable iff (!rst_n)
    reg_wr && reg_addr == dmp_pkg::DMP_OFS_DAT && reg_wdata[5:2] == 4'h3 ##1 !reg_wr
    |=> mic_data_pin_oe && mic_data_pin_o == $past(reg_wdata[0], 2))
    else $error("data pin write not applied");
  a_rsvd_reads_zero: assert property (@(posedge clk) disable iff (!rst_n)
    reg_addr == dmp_pkg::DMP_OFS_CLK |=> reg_rdata[7:6] == 2'b00)
    else $error("reserved bits nonzero");
  c_wr_clk: cover property (@(posedge clk) reg_wr && reg_addr == dmp_pkg::DMP_OFS_CLK);
  c_wr_dat: cover property (@(posedge clk) reg_wr && reg_addr == dmp_pkg::DMP_OFS_DAT);
endmodule
`default_nettype wire

/* tb/dmp_pad_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Far-side audio logic on one pad: drives a level when enabled, else leaves it floating.
module dmp_pad_model (
  input  wire logic clk,     // System clock.
  input  wire logic dut_oe,  // Block drives the pad.
  input  wire logic dut_o,   // Block drive level.
  input  wire logic ext_en,  // Far side drives the pad.
  input  wire logic ext_lvl, // Far side drive level.
  output logic      pad      // Resolved pad level.
);
  logic flt = 1'b0;
  // The pad has no pull, so a floating pad wanders instead of holding its last level.
  always @(posedge clk)
  begin
    flt <= ~flt;
  end
  assign pad = dut_oe ? dut_o : (ext_en ? ext_lvl : flt);
endmodule
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic       clk;
  logic       rst_n;
  logic [7:0] reg_addr;
  logic       reg_wr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [5:0] src;
  logic [1:0] ext_en;
  logic [1:0] ext_lvl;
  logic [1:0] pad;
  logic [1:0] oe;
  logic [1:0] po;
  logic [1:0] pin;
  logic [1:0] pgpi;
  logic [7:0] v;
  logic       e;
  int         failures;
  int         num_checks;
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end

  dmp_ctrl dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .divided_clock_output_src(src[0]), .int_one(src[1]),
    .int_two(src[2]), .sbclk_src(src[3]), .swclk_src(src[4]), .modclk_src(src[5]),
    .mic_clock_pin_i(pad[0]), .mic_clock_pin_o(po[0]), .mic_clock_pin_oe(oe[0]),
    .mic_clock_pin_in(pin[0]), .mic_clock_pin_gpi(pgpi[0]), .mic_data_pin_i(pad[1]),
    .mic_data_pin_o(po[1]), .mic_data_pin_oe(oe[1]), .mic_data_pin_in(pin[1]),
    .mic_data_pin_gpi(pgpi[1]));
  dmp_pad_model u_pad0 (.clk(clk), .dut_oe(oe[0]), .dut_o(po[0]), .ext_en(ext_en[0]),
    .ext_lvl(ext_lvl[0]), .pad(pad[0]));
  dmp_pad_model u_pad1 (.clk(clk), .dut_oe(oe[1]), .dut_o(po[1]), .ext_en(ext_en[1]),
    .ext_lvl(ext_lvl[1]), .pad(pad[1]));

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    @(posedge clk);
    #1;
    d = reg_rdata;
  endtask

  // The far side drives both pads high while the modes are still at reset.
  task t_reset;
    for (int p = 0; p < 2; p++)
    begin
      rd(8'h33 + p[7:0], v);
      `CHK(v, 8'h00)
      `CHK(oe[p], 1'b0)
    end
    rd(8'h35, v);
    `CHK(v, 8'h00)
    rd(8'h32, v);
    `CHK(v, 8'h00)
  endtask

  task t_inputs;
    for (int p = 0; p < 2; p++)
      for (int m = 0; m < 3; m++)
        for (int l = 0; l < 2; l++)
        begin
          @(posedge clk);
          ext_lvl <= {l[0], l[0]};
          wr(8'h33 + p[7:0], {2'b00, m[3:0], 2'b00});
          repeat (2) @(posedge clk);
          #1;
          `CHK(pin[p], (m == 1) && l[0])
          `CHK(pgpi[p], (m == 2) && l[0])
          `CHK(oe[p], 1'b0)
          rd(8'h33 + p[7:0], v);
          `CHK(v, {2'b00, m[3:0], (m != 0) && l[0], 1'b0})
        end
  endtask

  // Bit 0 is written opposite to the expected level in every mode but general output.
  task t_modes;
    automatic logic [3:0] code [7] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha};
    logic [5:0] s;
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < 2; i++)
        for (int k = 0; k < 7; k++)
        begin
          s = i[0] ? 6'h15 : 6'h2a;
          e = (k == 0) ? s[0] : s[k - 1];
          @(posedge clk);
          ext_en <= 2'b00;
          src <= s;
          wr(8'h33 + p[7:0], {2'b00, code[k], 1'b0, (k == 0) ? e : ~e});
          `CHK({oe[p], po[p]}, {1'b1, e})
          rd(8'h33 + p[7:0], v);
          `CHK(v, {2'b00, code[k], e, (k == 0) ? e : ~e})
        end
  endtask

  task end_of_test;
    if (failures == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    src = 6'h00;
    ext_en = 2'b11;
    ext_lvl = 2'b11;
    failures = 0;
    num_checks = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_inputs();
    t_modes();
    end_of_test();
  end

  initial
  begin
    #200000;
    failures++;
    end_of_test();
  end
endmodule
`default_nettype wire
